// ==== logic/sfg_map.vh ====
// constants of the serial flash guard block
`ifndef SFG_MAP_VH
`define SFG_MAP_VH
// status bit positions in the 16-bit status word
`define SFG_BIT_BUSY      0
`define SFG_BIT_WEL       1
`define SFG_BIT_BP_LO     2
`define SFG_BIT_BP_HI     4
`define SFG_BIT_TB        5
`define SFG_BIT_SEC       6
`define SFG_BIT_GML       7
`define SFG_BIT_GMH       8
`define SFG_BIT_QE        9
`define SFG_BIT_CMP       14
`define SFG_BIT_SUS       15
// non-volatile reset value, all protection off
`define SFG_NV_RESET      16'h0000
// opcodes
`define SFG_OP_WREN       8'h06
`define SFG_OP_WRDI       8'h04
`define SFG_OP_RDSR1      8'h05
`define SFG_OP_RDSR2      8'h35
`define SFG_OP_WRSR       8'h01
`define SFG_OP_PP         8'h02
`define SFG_OP_QPP        8'h32
`define SFG_OP_SE         8'h20
`define SFG_OP_BE32       8'h52
`define SFG_OP_BE64       8'hD8
`define SFG_OP_CE         8'hC7
`define SFG_OP_CE2        8'h60
`define SFG_OP_DP         8'hB9
`define SFG_OP_RDP        8'hAB
`define SFG_OP_SUS1       8'h75
`define SFG_OP_SUS2       8'hB0
`define SFG_OP_RES1       8'h7A
`define SFG_OP_RES2       8'h30
`define SFG_OP_SCER       8'h44
`define SFG_OP_SCPR       8'h42
// timing
`define SFG_CLK_MHZ       100
`define SFG_TPUW_US       5000
`define SFG_TPUW_CYC      (`SFG_TPUW_US * `SFG_CLK_MHZ)
`define SFG_TOP_US        3000
`define SFG_TOP_CYC       (`SFG_TOP_US * `SFG_CLK_MHZ)
`endif

// ==== logic/sfg_sync.v ====
// two-flop synchroniser for one pin
`timescale 1ns/100ps
module sfg_sync (
    // clock and reset
    input  wire ref_clk,
    input  wire rst_b,
    // pin and result
    input  wire pin_in,
    output reg  pin_sync
);
    reg meta_r;
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            meta_r   <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            meta_r   <= pin_in;
            pin_sync <= meta_r;
        end
    end
endmodule // sfg_sync

// ==== logic/sfg_region.v ====
// protected region check for a target address range
`timescale 1ns/100ps
module sfg_region (
    // protection bits
    input  wire [2:0]  region_size_bits,
    input  wire        top_bottom_select,
    input  wire        small_unit_select,
    input  wire        invert_region,
    // target range, inclusive
    input  wire [18:0] lo_addr,
    input  wire [18:0] hi_addr,
    // result
    output reg         hit
);
    reg [19:0] span;
    reg [19:0] p_lo;
    reg [19:0] p_hi;
    reg        none;
    always @* begin
        span = 20'h00000;
        none = 1'b0;
        if (region_size_bits == 3'h0) begin
            none = 1'b1;
        end else if (!small_unit_select) begin
            if (region_size_bits[2])
                span = 20'h80000;
            else
                span = 20'h10000 << (region_size_bits[1:0] - 2'h1);
        end else begin
            if (region_size_bits == 3'h7)
                span = 20'h80000;
            else if (region_size_bits[2])
                span = 20'h08000;
            else
                span = 20'h01000 << (region_size_bits[1:0] - 2'h1);
        end
        if (top_bottom_select) begin
            p_lo = 20'h00000;
            p_hi = span - 20'h00001;
        end else begin
            p_lo = 20'h80000 - span;
            p_hi = 20'h7FFFF;
        end
        // inverted region: complement of the plain one
        if (invert_region) begin
            if (none)
                hit = 1'b1;
            else if (span == 20'h80000)
                hit = 1'b0;
            else if (top_bottom_select)
                hit = ({1'b0, hi_addr} > p_hi);
            else
                hit = ({1'b0, lo_addr} < p_lo);
        end else begin
            hit = !none && ({1'b0, hi_addr} >= p_lo) && ({1'b0, lo_addr} <= p_hi);
        end
    end
endmodule // sfg_region

// ==== logic/sfg_core.v ====
// serial flash pause, write guard and status control
`timescale 1ns/100ps
`include "sfg_map.vh"
module sfg_core #(
    parameter TPUW_CYC = `SFG_TPUW_CYC,
    parameter TOP_CYC  = `SFG_TOP_CYC
) (
    // clock and reset
    input  wire ref_clk,
    input  wire rst_b,
    // serial bus pins
    input  wire cs_b,
    input  wire sclk,
    input  wire sdi,
    output reg  sdo_out,
    output reg  sdo_oe,
    // pause / lane-3 and write-protect / lane-2 pins
    input  wire pause_b,
    input  wire wp_b,
    // state view
    output reg  paused_r,
    output reg  quad_lane_enable
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire cs_s, clk_s, di_s, ps_s, wp_s;
    sfg_sync u_cs (.ref_clk(ref_clk), .rst_b(rst_b), .pin_in(cs_b),    .pin_sync(cs_s));
    sfg_sync u_ck (.ref_clk(ref_clk), .rst_b(rst_b), .pin_in(sclk),    .pin_sync(clk_s));
    sfg_sync u_di (.ref_clk(ref_clk), .rst_b(rst_b), .pin_in(sdi),     .pin_sync(di_s));
    sfg_sync u_ps (.ref_clk(ref_clk), .rst_b(rst_b), .pin_in(pause_b), .pin_sync(ps_s));
    sfg_sync u_wp (.ref_clk(ref_clk), .rst_b(rst_b), .pin_in(wp_b),    .pin_sync(wp_s));

    reg clk_d_r, cs_d_r, ps_d_r;
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            clk_d_r <= 1'b0;
            cs_d_r  <= 1'b1;
            ps_d_r  <= 1'b1;
        end else begin
            clk_d_r <= clk_s;
            cs_d_r  <= cs_s;
            ps_d_r  <= ps_s;
        end
    end
    wire clk_rise = clk_s & ~clk_d_r;
    wire clk_fall = ~clk_s & clk_d_r;
    wire cs_rise  = cs_s & ~cs_d_r;

    // ------------------------------------------------------------
    // status bits
    // ------------------------------------------------------------
    reg        busy_r, wel_r, sus_r, gmh_r, gml_r, tb_r, sec_r, cmp_r;
    reg [2:0]  bp_r;
    wire [15:0] status = {sus_r, cmp_r, 4'h0, quad_lane_enable, gmh_r, gml_r,
                          sec_r, tb_r, bp_r, wel_r, busy_r};

    // ------------------------------------------------------------
    // pause tracking
    // ------------------------------------------------------------
    // pause needs quad off
    wire pause_ok = ~quad_lane_enable & ~cs_s;
    reg  paused_nxt;
    always @* begin
        paused_nxt = paused_r;
        if (!pause_ok) begin
            paused_nxt = 1'b0;
        end else if (!paused_r) begin
            if (!ps_s && (clk_fall || (!clk_s && ps_d_r)))
                paused_nxt = 1'b1;
        end else begin
            if (ps_s && (clk_fall || (!clk_s && !ps_d_r)))
                paused_nxt = 1'b0;
        end
    end
    // next value also gates the output enable
    always @(posedge ref_clk) begin
        if (!rst_b)
            paused_r <= 1'b0;
        else
            paused_r <= paused_nxt;
    end
    wire sh_in  = clk_rise & ~cs_s & ~paused_r;
    wire sh_out = clk_fall & ~cs_s & ~paused_r;

    // ------------------------------------------------------------
    // frame shifter
    // ------------------------------------------------------------
    reg [5:0]  bitcnt_r;
    reg [7:0]  op_r;
    reg [23:0] arg_r;
    reg [15:0] tx_r;
    reg        rd_r;
    wire [7:0] sh_nxt = {op_r[6:0], di_s};
    always @(posedge ref_clk) begin
        if (!rst_b || cs_s) begin
            bitcnt_r <= 6'h00;
            op_r     <= 8'h00;
            arg_r    <= 24'h000000;
        end else if (sh_in) begin
            if (bitcnt_r < 6'h08)
                op_r <= sh_nxt;
            // first three bytes after the opcode kept, later bytes not shifted in
            else if (bitcnt_r < 6'h20)
                arg_r <= {arg_r[22:0], di_s};
            if (bitcnt_r != 6'h3F)
                bitcnt_r <= bitcnt_r + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // power-up delay and operation timer
    // ------------------------------------------------------------
    reg [31:0] pu_r, op_cnt_r;
    reg        pdown_r;
    wire pu_done = (pu_r == 32'h0);
    always @(posedge ref_clk) begin
        if (!rst_b)
            pu_r <= TPUW_CYC[31:0];
        else if (!pu_done)
            pu_r <= pu_r - 32'h1;
    end

    // ------------------------------------------------------------
    // command decode at deselect
    // ------------------------------------------------------------
    wire is_wr   = (op_r == `SFG_OP_PP) || (op_r == `SFG_OP_QPP) || (op_r == `SFG_OP_SE) ||
                   (op_r == `SFG_OP_BE32) || (op_r == `SFG_OP_BE64) ||
                   (op_r == `SFG_OP_CE) || (op_r == `SFG_OP_CE2) ||
                   (op_r == `SFG_OP_SCER) || (op_r == `SFG_OP_SCPR);
    wire is_arr  = is_wr && (op_r != `SFG_OP_SCER) && (op_r != `SFG_OP_SCPR);
    wire is_sus  = (op_r == `SFG_OP_SUS1) || (op_r == `SFG_OP_SUS2);
    wire is_res  = (op_r == `SFG_OP_RES1) || (op_r == `SFG_OP_RES2);
    wire cmd_done = cs_rise & (bitcnt_r >= 6'h08);
    wire has_addr = (bitcnt_r >= 6'h20);
    wire has_sr1  = (bitcnt_r >= 6'h10);
    wire has_sr2  = (bitcnt_r >= 6'h18);

    // target range for array writes
    reg [18:0] t_lo, t_hi;
    always @* begin
        t_lo = arg_r[18:0];
        t_hi = arg_r[18:0];
        case (op_r)
            `SFG_OP_SE: begin
                t_lo = {arg_r[18:12], 12'h000};
                t_hi = {arg_r[18:12], 12'hFFF};
            end
            `SFG_OP_BE32: begin
                t_lo = {arg_r[18:15], 15'h0000};
                t_hi = {arg_r[18:15], 15'h7FFF};
            end
            `SFG_OP_BE64: begin
                t_lo = {arg_r[18:16], 16'h0000};
                t_hi = {arg_r[18:16], 16'hFFFF};
            end
            `SFG_OP_CE, `SFG_OP_CE2: begin
                t_lo = 19'h00000;
                t_hi = 19'h7FFFF;
            end
            default: begin
                t_lo = {arg_r[18:8], 8'h00};
                t_hi = {arg_r[18:8], 8'hFF};
            end
        endcase
    end
    wire prot_hit;
    sfg_region u_reg (
        .region_size_bits  (bp_r),
        .top_bottom_select (tb_r),
        .small_unit_select (sec_r),
        .invert_region     (cmp_r),
        .lo_addr           (t_lo),
        .hi_addr           (t_hi),
        .hit               (prot_hit)
    );
    wire op_needs_addr = (op_r != `SFG_OP_CE) && (op_r != `SFG_OP_CE2);

    wire wp_count = ~quad_lane_enable & ~wp_s;
    wire sr_ok = wel_r & ~gmh_r & ~(gml_r & wp_count);

    // ------------------------------------------------------------
    // status update
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            busy_r <= 1'b0;
            wel_r  <= 1'b0;
            sus_r  <= 1'b0;
            bp_r   <= 3'h0;
            tb_r   <= 1'b0;
            sec_r  <= 1'b0;
            gml_r  <= 1'b0;
            gmh_r  <= 1'b0;
            cmp_r  <= 1'b0;
            quad_lane_enable <= 1'b0;
            pdown_r  <= 1'b0;
            op_cnt_r <= 32'h0;
        end else begin
            if (busy_r) begin
                if (op_cnt_r == 32'h0) begin
                    busy_r <= 1'b0;
                    wel_r  <= 1'b0;
                end else if (!sus_r) begin
                    op_cnt_r <= op_cnt_r - 32'h1;
                end
            end
            if (cmd_done) begin
                if (pdown_r) begin
                    if (op_r == `SFG_OP_RDP)
                        pdown_r <= 1'b0;
                end else if (busy_r) begin
                    if (is_sus)
                        sus_r <= 1'b1;
                    else if (is_res)
                        sus_r <= 1'b0;
                end else begin
                    case (op_r)
                        `SFG_OP_WREN: if (pu_done) wel_r <= 1'b1;
                        `SFG_OP_WRDI: wel_r <= 1'b0;
                        `SFG_OP_DP:   pdown_r <= 1'b1;
                        `SFG_OP_WRSR: begin
                            if (pu_done && sr_ok && has_sr1) begin
                                bp_r  <= arg_r[(has_sr2 ? 12 : 4) -: 3];
                                tb_r  <= has_sr2 ? arg_r[13] : arg_r[5];
                                sec_r <= has_sr2 ? arg_r[14] : arg_r[6];
                                gml_r <= has_sr2 ? arg_r[15] : arg_r[7];
                                if (has_sr2) begin
                                    gmh_r <= arg_r[0];
                                    quad_lane_enable <= arg_r[1];
                                    cmp_r <= arg_r[6];
                                end
                                busy_r   <= 1'b1;
                                op_cnt_r <= TOP_CYC[31:0];
                            end
                        end
                        default: begin
                            if (is_wr && pu_done && wel_r &&
                                (!op_needs_addr || has_addr) &&
                                !(is_arr && prot_hit)) begin
                                busy_r   <= 1'b1;
                                op_cnt_r <= TOP_CYC[31:0];
                            end
                        end
                    endcase
                    if (is_res)
                        sus_r <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // status read output
    // ------------------------------------------------------------
    wire rd_start = ~cs_s & (bitcnt_r == 6'h08) & ~rd_r & ~pdown_r &
                    ((op_r == `SFG_OP_RDSR1) || (op_r == `SFG_OP_RDSR2));
    always @(posedge ref_clk) begin
        if (!rst_b || cs_s) begin
            rd_r    <= 1'b0;
            tx_r    <= 16'h0000;
            sdo_out <= 1'b0;
            sdo_oe  <= 1'b0;
        end else begin
            if (rd_start) begin
                rd_r <= 1'b1;
                tx_r <= (op_r == `SFG_OP_RDSR1) ? {status[7:0], status[7:0]}
                                                : {status[15:8], status[15:8]};
            end else if (rd_r && sh_out) begin
                sdo_out <= tx_r[15];
                tx_r    <= {tx_r[14:0], tx_r[15]};
            end
            sdo_oe <= rd_r & ~paused_nxt;
        end
    end
endmodule // sfg_core

// ==== sim/sfg_core_sva.sv ====
// port assertions for the serial flash guard core
`timescale 1ns/100ps
module sfg_core_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // serial pins
    input wire logic cs_b,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic pause_b,
    input wire logic wp_b,
    // state view
    input wire logic paused_r,
    input wire logic quad_lane_enable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_pause_no_drive: assert property (
        paused_r |-> !sdo_oe) else $error("sdo driven in pause");
    a_pause_sdo_held: assert property (
        paused_r[*4] |-> $stable(sdo_out)) else $error("sdo moved in pause");
    a_pause_enter: assert property (
        (!sclk)[*3] ##0 ($fell(pause_b) && !cs_b && !quad_lane_enable)
        ##1 (!pause_b && !sclk && !cs_b)[*6] |-> paused_r) else $error("pause not entered");
    a_pause_wait_fall: assert property (
        sclk[*3] ##0 ($fell(pause_b) && !cs_b) ##1 (sclk && !pause_b)[*6] |-> !paused_r)
        else $error("pause entered with clock high");
    a_pause_leave: assert property (
        (!sclk)[*3] ##0 $rose(pause_b) ##1 (pause_b && !sclk)[*6] |-> !paused_r)
        else $error("pause not left");
    a_pause_cs_drop: assert property (
        cs_b[*6] |-> !paused_r) else $error("pause kept after deselect");
    a_quad_no_pause: assert property (
        quad_lane_enable |-> !paused_r) else $error("pause with quad lanes");
    a_idle_no_drive: assert property (
        cs_b[*6] |-> !sdo_oe) else $error("sdo driven while deselected");
    a_reset_clear: assert property (
        $rose(rst_b) |-> !quad_lane_enable && !paused_r && !sdo_oe) else $error("reset left state");
endmodule // sfg_core_sva

bind sfg_core sfg_core_sva u_sva (
    .ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .sdi(sdi),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .pause_b(pause_b), .wp_b(wp_b),
    .paused_r(paused_r), .quad_lane_enable(quad_lane_enable));

// ==== sim/sfg_host.sv ====
// host serial controller model, mode 0, clock still between frames
`timescale 1ns/100ps
module sfg_host (
    // pins toward the flash
    output logic cs_b,
    output logic sclk,
    output logic sdi,
    output logic pause_b,
    output logic wp_b,
    // data back from the flash
    input  wire logic sdo_out,
    input  wire logic sdo_oe
);
    logic last_q;
    // released line toggles, never a stale level
    wire  sdo_w = sdo_oe ? sdo_out : ~last_q;
    always @(posedge sclk) last_q <= sdo_w;
    initial begin
        {cs_b, sclk, sdi, pause_b, wp_b, last_q} = 6'b100110;
    end
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            #62.5 sclk = 1'b1;
            rx[i] = sdo_w;
            #62.5 sclk = 1'b0;
        end
    endtask
    task automatic frame(input logic [7:0] op, input int n, input logic [31:0] d,
                         output logic [7:0] rx);
        cs_b = 1'b0;
        #62.5 xfer(op, rx);
        for (int k = n - 1; k >= 0; k--) xfer(d[8*k +: 8], rx);
        #62.5 cs_b = 1'b1;
        #200;
    endtask
    // select held low across the pause
    task automatic pause_read(input bit clk_hi, input logic [7:0] junk, output logic [7:0] rx);
        logic [7:0] dummy;
        cs_b = 1'b0;
        #62.5 xfer(8'h05, dummy);
        sclk = clk_hi;
        #100 pause_b = 1'b0;
        #200 sclk = 1'b0;
        #200 xfer(junk, dummy);
        // odd pulse count skews the read unless ignored
        repeat (3) begin
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        #100 pause_b = 1'b1;
        #200 xfer(8'h00, rx);
        #62.5 cs_b = 1'b1;
        #200;
    endtask
endmodule // sfg_host

// ==== sim/serial_flash_hold_and_write_guard_tb_top.sv ====
// self-checking bench for the serial flash guard core
`timescale 1ns/100ps
module serial_flash_hold_and_write_guard_tb_top;
    logic        ref_clk = 1'b0;
    logic        rst_b   = 1'b0;
    wire         cs_b, sclk, sdi, pause_b, wp_b, sdo_out, sdo_oe, paused_r, quad_lane_enable;
    int          err_total   = 0;
    int          checks_done = 0;
    logic [15:0] exp_sr      = 16'h0000;
    logic [7:0]  rx;
    logic [7:0]  sus_op [2]  = '{8'h75, 8'hB0};
    logic [7:0]  res_op [2]  = '{8'h7A, 8'h30};
    always #5 ref_clk = ~ref_clk;
    sfg_core #(.TPUW_CYC(400), .TOP_CYC(1500)) uut (
        .ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .pause_b(pause_b), .wp_b(wp_b),
        .paused_r(paused_r), .quad_lane_enable(quad_lane_enable));
    sfg_host u_host (
        .cs_b(cs_b), .sclk(sclk), .sdi(sdi), .pause_b(pause_b), .wp_b(wp_b),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op);
        u_host.frame(op, 0, 32'h0, rx);
    endtask
    task automatic rd(input bit hi, output logic [7:0] v);
        u_host.frame(hi ? 8'h35 : 8'h05, 1, 32'h0, v);
    endtask
    task automatic chk_sr();
        logic [7:0] v;
        rd(0, v);
        chk("status low", v, exp_sr[7:0]);
        rd(1, v);
        chk("status high", v, exp_sr[15:8]);
    endtask
    // first look must show busy with the latch still set
    task automatic wait_idle();
        logic [7:0] v;
        rd(0, v);
        chk("busy", {6'h00, v[1:0]}, 8'h03);
        for (int n = 0; n < 40 && v[0] !== 1'b0; n++) rd(0, v);
    endtask
    task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi, input bit ok);
        cmd(8'h06);
        exp_sr[1] = 1'b1;
        u_host.frame(8'h01, 2, {16'h0, lo, hi}, rx);
        if (ok) begin
            wait_idle();
            exp_sr = {hi, lo};
        end
        chk_sr();
    endtask
    task automatic prog(input logic [23:0] a, input bit ok);
        cmd(8'h06);
        exp_sr[1] = 1'b1;
        u_host.frame(8'h02, 4, {a, 8'h5A}, rx);
        if (ok) begin
            wait_idle();
            exp_sr[1] = 1'b0;
        end
        chk_sr();
    endtask
    initial begin
        #900000;
        err_total++;
        give_verdict();
    end
    initial begin
        logic [7:0] v;
        void'($urandom(32'hA06AD55B));
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        cmd(8'h06);
        chk_sr();
        cmd(8'h06);
        exp_sr[1] = 1'b1;
        chk_sr();
        cmd(8'h04);
        exp_sr[1] = 1'b0;
        u_host.frame(8'h01, 1, 32'h1C, rx);
        chk_sr();
        foreach (sus_op[i]) begin
            cmd(8'h06);
            u_host.frame(8'h02, 4, 32'h5A, rx);
            cmd(sus_op[i]);
            rd(1, v);
            chk("suspend", v, 8'h80);
            cmd(res_op[i]);
            cmd(8'hB9);
            wait_idle();
            chk_sr();
            cmd(8'h06);
            exp_sr[1] = 1'b1;
            chk_sr();
            cmd(8'h04);
            exp_sr[1] = 1'b0;
        end
        wrsr(8'($urandom()) & 8'h7C, 8'h00, 1);
        for (int c = 0; c < 2; c++) begin
            wrsr(8'h04, c[0] ? 8'h40 : 8'h00, 1);
            prog(24'h070000, c[0]);
            prog(24'h000000, !c[0]);
        end
        for (int h = 0; h < 2; h++) begin
            u_host.pause_read(h[0], 8'($urandom()), v);
            chk("pause read", v, exp_sr[7:0]);
        end
        @(negedge ref_clk) u_host.wp_b = 1'b0;
        wrsr(8'h80, 8'h00, 1);
        wrsr(8'h84, 8'h00, 0);
        @(negedge ref_clk) u_host.wp_b = 1'b1;
        wrsr(8'h80, 8'h02, 1);
        chk("quad", {7'h00, quad_lane_enable}, 8'h01);
        u_host.pause_read(1'b0, 8'($urandom()), v);
        // no pause: eleven extra clocks rotate the byte by three
        chk("quad read", v, {exp_sr[4:0], exp_sr[7:5]});
        @(negedge ref_clk) u_host.wp_b = 1'b0;
        wrsr(8'h80, 8'h00, 1);
        @(negedge ref_clk) u_host.wp_b = 1'b1;
        wrsr(8'h00, 8'h00, 1);
        cmd(8'hB9);
        cmd(8'h06);
        cmd(8'hAB);
        chk_sr();
        wrsr(8'h00, 8'h01, 1);
        wrsr(8'h1C, 8'h00, 0);
        @(negedge ref_clk) rst_b = 1'b0;
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        cmd(8'h06);
        exp_sr = 16'h0000;
        chk_sr();
        give_verdict();
    end
endmodule // serial_flash_hold_and_write_guard_tb_top
